// ==== design/ifl_pkg.sv ====
/*
  Shared constants and types for the two-wire bus interrupt flag logic:
  register offsets, field layouts, reset values and the receive states.
  Assumes a 32-bit AXI4-Lite register bus with a 5-bit byte address.
*/
package ifl_pkg;

  // ==========================================================
  // Register map
  localparam int IFL_ADDR_W = 5;
  localparam logic [IFL_ADDR_W-1:0] IFL_OFS_CTRL = 5'h00;
  localparam logic [IFL_ADDR_W-1:0] IFL_OFS_OWN = 5'h04;
  localparam logic [IFL_ADDR_W-1:0] IFL_OFS_STAT = 5'h08;
  localparam logic [IFL_ADDR_W-1:0] IFL_OFS_MASK = 5'h0C;
  localparam logic [IFL_ADDR_W-1:0] IFL_OFS_DATA = 5'h10;

  localparam logic [1:0] IFL_RESP_OKAY = 2'h0;
  localparam logic [1:0] IFL_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Field layouts
  // Bit 0 of the status is the common flag; bit 0 of the mask is its enable
  typedef struct packed {
    logic arbitrationLostFlag;
    logic addressedAsSlaveFlag;
    logic byteDoneFlag;
    logic busIrqFlag;
  } ifl_stat_t;

  typedef struct packed {
    logic tenBitMode;
    logic generalCallEnable;
  } ifl_ctrl_t;

  localparam ifl_stat_t IFL_MASK_RST = 4'h0;
  localparam ifl_stat_t IFL_STAT_RST = 4'h0;
  localparam ifl_ctrl_t IFL_CTRL_RST = 2'h0;

  // ==========================================================
  // Serial framing
  localparam logic [3:0] IFL_ACK_RISE = 4'h8;
  localparam logic [3:0] IFL_LAST_RISE = 4'h9;
  localparam logic [4:0] IFL_TEN_PREFIX = 5'h1E;
  localparam logic [7:0] IFL_GC_ADDR = 8'h00;

  typedef enum logic [2:0] {
    IFL_IDLE,
    IFL_ADDR,
    IFL_ADDR2,
    IFL_DATA,
    IFL_SKIP
  } ifl_state_t;

endpackage

// ==== design/ifl_irq_flag_logic.sv ====
/*
  Interrupt flag logic of a two-wire serial bus slave: watches SCL/SDA,
  acknowledges its own, general call and 10-bit addresses, and gathers
  byte-done, address-match and arbitration-lost events into one flag.
  Assumes SCL/SDA arrive asynchronously, arbLostEvt is a one-cycle pulse
  on mclk from the rest of the controller, and an AXI4-Lite master.
*/
// Behaviour
// (RL1) One interrupt output serves every event of the controller.
// (RL2) Interrupt output is the common flag gated by its enable bit; the code ORs every status bit gated by its own mask bit.
// (RL3) Byte done, address match or arbitration lost set the common flag.
// (RL4) The flag stays set until software writes one to it.
// (RL5) Byte-done status sets at the falling edge of the ninth clock.
// (RL6) Each source keeps its own readable status bit.
// (RL7) Software checks for address zero to spot a general call.
// (RL8) First byte of a matching 10-bit address raises an interrupt.
// (RL9) Software ignores the data register on that 10-bit interrupt.
// (RL10) General call enabled: match address zero, receive, set address flag.
// (RL11) General call disabled: do not acknowledge it, ignore its data; the code still answers it as its own address when that is zero in 7-bit mode.
// (RL12) An event in the clearing cycle keeps the flag set.
module ifl_irq_flag_logic
  import ifl_pkg::*;
#(
  parameter logic [9:0] OWN_ADDR_RST = 10'h000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [IFL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IFL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic arbLostEvt,
  output logic busIrq
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pinRaw;
  logic [1:0] pinLvl;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  assign pinRaw = {sdaIn, sclIn};

  for (genvar g = 0; g < 2; g++) begin : gSync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    // Idle bus is high; a change counts only once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
        s3_reg <= 1'b1;
        lvl_reg <= 1'b1;
      end else begin
        s1_reg <= pinRaw[g];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          lvl_reg <= s3_reg;
        end
      end
    end
    assign pinLvl[g] = lvl_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= pinLvl[0];
      sdaPrev_reg <= pinLvl[1];
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign sclRise = pinLvl[0] & ~sclPrev_reg;
  assign sclFall = ~pinLvl[0] & sclPrev_reg;
  // Our own acknowledge is seen through the synchroniser after SCL is seen high
  // again; SDA edges while we pull it must not read as a start or stop
  assign startCond = pinLvl[0] & sclPrev_reg & sdaPrev_reg & ~pinLvl[1] & ~sdaOe;
  assign stopCond = pinLvl[0] & sclPrev_reg & ~sdaPrev_reg & pinLvl[1] & ~sdaOe;

  // ==========================================================
  // Registers
  ifl_ctrl_t ctrl_reg;
  logic [9:0] ownAddr_reg;
  ifl_stat_t stat_reg;
  ifl_stat_t stat_next;
  ifl_stat_t mask_reg;
  logic [7:0] busData_reg;

  // ==========================================================
  // Receive engine
  ifl_state_t state_reg;
  ifl_state_t pendState_reg;
  ifl_state_t goState;
  logic [3:0] riseCnt_reg;
  logic [7:0] shift_reg;
  logic ack_reg;
  logic pendMatch_reg;
  logic pendTen_reg;
  logic tenHit_reg;
  logic matchAck;
  logic matchAddr;
  logic tenFirst;
  logic ackFall;
  logic ninthFall;

  assign ackFall = sclFall && riseCnt_reg == IFL_ACK_RISE && state_reg != IFL_IDLE;
  assign ninthFall = sclFall && riseCnt_reg == IFL_LAST_RISE && state_reg != IFL_IDLE;

  always_comb begin
    matchAck = 1'b0;
    matchAddr = 1'b0;
    tenFirst = 1'b0;
    goState = IFL_SKIP;
    unique case (state_reg)
      IFL_ADDR: begin
        if (!ctrl_reg.tenBitMode && shift_reg[7:1] == ownAddr_reg[6:0]) begin
          matchAck = 1'b1;
          matchAddr = 1'b1;
          goState = shift_reg[0] ? IFL_SKIP : IFL_DATA;
        end else if (ctrl_reg.generalCallEnable && shift_reg == IFL_GC_ADDR) begin
          matchAck = 1'b1; // [RL10]
          matchAddr = 1'b1; // [RL10]
          goState = IFL_DATA;
        end else if (ctrl_reg.tenBitMode && shift_reg[7:3] == IFL_TEN_PREFIX
                     && shift_reg[2:1] == ownAddr_reg[9:8]) begin
          if (!shift_reg[0]) begin
            matchAck = 1'b1;
            tenFirst = 1'b1; // [RL8]
            goState = IFL_ADDR2;
          end else if (tenHit_reg) begin
            matchAck = 1'b1;
            matchAddr = 1'b1;
          end
        end
        // Address zero with the enable clear falls through unanswered unless 7-bit mode and own address zero [RL11]
      end
      IFL_ADDR2: begin
        if (shift_reg == ownAddr_reg[7:0]) begin
          matchAck = 1'b1;
          matchAddr = 1'b1;
          goState = IFL_DATA;
        end
      end
      IFL_DATA: begin
        matchAck = 1'b1;
        goState = IFL_DATA;
      end
      IFL_IDLE, IFL_SKIP: begin
        goState = IFL_SKIP;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IFL_IDLE;
      pendState_reg <= IFL_IDLE;
      riseCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_reg <= 1'b0;
      pendMatch_reg <= 1'b0;
      pendTen_reg <= 1'b0;
    end else if (startCond || stopCond) begin
      state_reg <= startCond ? IFL_ADDR : IFL_IDLE;
      riseCnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      pendMatch_reg <= 1'b0;
      pendTen_reg <= 1'b0;
    end else if (state_reg != IFL_IDLE) begin
      if (sclRise) begin
        riseCnt_reg <= riseCnt_reg + 4'h1;
        if (riseCnt_reg < IFL_ACK_RISE) begin
          shift_reg <= {shift_reg[6:0], pinLvl[1]};
        end
      end
      if (ackFall) begin
        ack_reg <= matchAck;
        pendMatch_reg <= matchAddr;
        pendTen_reg <= tenFirst;
        pendState_reg <= goState;
      end
      if (ninthFall) begin
        riseCnt_reg <= 4'h0;
        state_reg <= pendState_reg;
        ack_reg <= 1'b0;
        pendMatch_reg <= 1'b0;
        pendTen_reg <= 1'b0;
      end
    end
  end

  // Ten-bit header seen; a repeated start with read may then address us
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tenHit_reg <= 1'b0;
    end else if (stopCond) begin
      tenHit_reg <= 1'b0;
    end else if (ninthFall && pendTen_reg) begin
      tenHit_reg <= 1'b1;
    end
  end

  // Acknowledge drive: low from the eighth fall to the ninth fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (startCond || stopCond || ninthFall) begin
      sdaOe <= 1'b0;
    end else if (ackFall) begin
      sdaOe <= matchAck; // [RL11]
    end
  end

  // Unacknowledged bytes never reach the data register [RL11]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busData_reg <= 8'h00;
    end else if (ninthFall && ack_reg) begin
      busData_reg <= shift_reg;
    end
  end

  // ==========================================================
  // Interrupt status and request
  ifl_stat_t setMask;
  ifl_stat_t clrMask;
  logic evtByte;
  logic evtAddr;
  logic wrEn;
  logic [IFL_ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  assign evtByte = ninthFall & ack_reg; // [RL5] [RL8]
  assign evtAddr = ninthFall & pendMatch_reg; // [RL10]

  always_comb begin
    setMask.byteDoneFlag = evtByte;
    setMask.addressedAsSlaveFlag = evtAddr;
    setMask.arbitrationLostFlag = arbLostEvt;
    setMask.busIrqFlag = evtByte | evtAddr | arbLostEvt; // [RL3]
    clrMask = IFL_STAT_RST;
    if (wrEn && awAddr_reg == IFL_OFS_STAT && wStrb_reg[0]) begin
      clrMask = ifl_stat_t'(wData_reg[3:0]); // [RL4]
    end
    stat_next = (stat_reg & ~clrMask) | setMask; // [RL12] [RL6]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= IFL_STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // The single request line [RL1]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busIrq <= 1'b0;
    end else begin
      busIrq <= |(stat_reg & mask_reg); // [RL2]
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic awHeld_reg;
  logic wHeld_reg;
  assign wrEn = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IFL_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHeld_reg & ~s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~wHeld_reg & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrEn) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_reg == IFL_OFS_CTRL || awAddr_reg == IFL_OFS_OWN
                        || awAddr_reg == IFL_OFS_STAT || awAddr_reg == IFL_OFS_MASK
                        || awAddr_reg == IFL_OFS_DATA) ? IFL_RESP_OKAY : IFL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= IFL_CTRL_RST;
      ownAddr_reg <= OWN_ADDR_RST;
      mask_reg <= IFL_MASK_RST;
    end else if (wrEn) begin
      if (awAddr_reg == IFL_OFS_CTRL && wStrb_reg[0]) begin
        ctrl_reg <= ifl_ctrl_t'(wData_reg[1:0]);
      end
      if (awAddr_reg == IFL_OFS_OWN && wStrb_reg[0]) begin
        ownAddr_reg[7:0] <= wData_reg[7:0];
      end
      if (awAddr_reg == IFL_OFS_OWN && wStrb_reg[1]) begin
        ownAddr_reg[9:8] <= wData_reg[9:8];
      end
      if (awAddr_reg == IFL_OFS_MASK && wStrb_reg[0]) begin
        mask_reg <= ifl_stat_t'(wData_reg[3:0]);
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= IFL_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= IFL_RESP_OKAY;
        unique case (s_axi_araddr)
          IFL_OFS_CTRL: s_axi_rdata <= 32'(ctrl_reg);
          IFL_OFS_OWN: s_axi_rdata <= 32'(ownAddr_reg);
          IFL_OFS_STAT: s_axi_rdata <= 32'(stat_reg); // [RL6]
          IFL_OFS_MASK: s_axi_rdata <= 32'(mask_reg);
          IFL_OFS_DATA: s_axi_rdata <= 32'(busData_reg);
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= IFL_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic flagClr;
  assign flagClr = clrMask.busIrqFlag;

  sequence ackPhase;
    ackFall && matchAck ##1 sdaOe;
  endsequence

  sequence byteEnd;
    ninthFall && ack_reg;
  endsequence

  a_irq_follows_flag: assert property ( // [RL2]
    stat_reg.busIrqFlag && mask_reg.busIrqFlag |=> busIrq)
    else $error("request missing while flag and enable set");
  a_irq_quiet: assert property ( // [RL1]
    !(|(stat_reg & mask_reg)) |=> !busIrq)
    else $error("request raised with no unmasked status");
  a_flag_sources: assert property ( // [RL3]
    evtByte || evtAddr || arbLostEvt |=> stat_reg.busIrqFlag && stat_reg != IFL_STAT_RST)
    else $error("source event did not set the common flag");
  a_flag_sticky: assert property ( // [RL4]
    stat_reg.busIrqFlag && !flagClr |=> stat_reg.busIrqFlag [*2] or ##1 $past(flagClr))
    else $error("flag dropped without a clearing write");
  a_flag_clear: assert property ( // [RL4]
    flagClr && !setMask.busIrqFlag |=> !stat_reg.busIrqFlag)
    else $error("write of one did not clear the flag");
  a_set_wins: assert property ( // [RL12]
    flagClr && setMask.busIrqFlag |=> stat_reg.busIrqFlag)
    else $error("event lost in clearing cycle");
  a_ninth_fall: assert property ( // [RL5]
    ackPhase ##[1:1000] byteEnd |=> stat_reg.byteDoneFlag && !sdaOe)
    else $error("byte done not set at ninth falling edge");
  a_arb_visible: assert property ( // [RL6]
    arbLostEvt |=> stat_reg.arbitrationLostFlag)
    else $error("arbitration lost status not kept");
  a_gc_nack: assert property ( // [RL11]
    ackFall && state_reg == IFL_ADDR && shift_reg == IFL_GC_ADDR && !ctrl_reg.generalCallEnable
    && !ctrl_reg.tenBitMode && ownAddr_reg[6:0] != shift_reg[7:1] |=> !sdaOe)
    else $error("general call acknowledged while disabled");
  a_gc_ack: assert property ( // [RL10]
    ackFall && state_reg == IFL_ADDR && shift_reg == IFL_GC_ADDR && ctrl_reg.generalCallEnable
    |=> sdaOe && pendMatch_reg)
    else $error("general call not acknowledged while enabled");
  a_ten_first: assert property ( // [RL8]
    ninthFall && pendTen_reg |=> stat_reg.busIrqFlag && stat_reg.byteDoneFlag)
    else $error("no interrupt after first 10-bit address byte");

endmodule

// ==== verif/ifl_bus_master_model.sv ====
/*
  Behavioural two-wire bus master that addresses the slave under test.
  Assumes the bench resolves SDA from both open-drain parties with a pull-up
  and that only this master drives SCL, which idles high between frames.
*/
module ifl_bus_master_model (
  output logic sclDrv,
  output logic sdaLow,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Line control
  initial begin
    sclDrv = 1'b1;
    sdaLow = 1'b0;
  end

  // Odd offset keeps pin changes away from the slave's clock edges
  // Releases SDA and raises SCL first, so it also serves as a repeated start
  task automatic startCond();
    #37;
    sdaLow = 1'b0;
    #200;
    sclDrv = 1'b1;
    #400;
    sdaLow = 1'b1;
    #400;
    sclDrv = 1'b0;
    #200;
  endtask

  task automatic stopCond();
    #37;
    sdaLow = 1'b1;
    #200;
    sclDrv = 1'b1;
    #400;
    sdaLow = 1'b0;
    #400;
  endtask

  // Eight bits MSB first at an 800 ns bit period, then the acknowledge slot
  task automatic sendByte(input logic [7:0] b, output logic ack);
    #37;
    for (int i = 7; i >= 0; i--) begin
      sdaLow = !b[i];
      #200;
      sclDrv = 1'b1;
      #400;
      sclDrv = 1'b0;
      #200;
    end
    sdaLow = 1'b0;
    #200;
    sclDrv = 1'b1;
    #200;
    ack = !sdaLine;
    #200;
    sclDrv = 1'b0;
    #200;
  endtask
endmodule

// ==== verif/tb.sv ====
/*
  Self-checking bench for the interrupt flag logic: register access over
  AXI4-Lite, bus frames from the master model, and the event pulse input.
  Assumes the package register map and the hand-over timing of the design.
*/
module tb
  import ifl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [IFL_ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic s_axi_wready;
  logic [IFL_ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic sclIn;
  logic sdaIn;
  logic sdaOut;
  logic sdaOe;
  logic arbLostEvt = 1'b0;
  logic busIrq;
  logic sdaLow;
  int nErrors = 0;
  int checked = 0;
  int cycles = 0;

  always #50 mclk = ~mclk;

  // Open-drain SDA with pull-up: low whenever either party pulls
  assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));

  ifl_irq_flag_logic dut_u (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn,
    .sdaIn, .sdaOut, .sdaOe, .arbLostEvt, .busIrq);

  ifl_bus_master_model mst_u (.sclDrv(sclIn), .sdaLow(sdaLow), .sdaLine(sdaIn));

  // ==========================================================
  // Checking and closing
  task automatic summarize();
    if (nErrors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask

  // Generous ceiling: the whole sequence needs about a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors++;
      summarize();
    end
  end

  // ==========================================================
  // Register bus tasks: flags are sampled on the falling edge, drive on the rising
  task automatic axiWr(input logic [IFL_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axiRd(input logic [IFL_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      ar = s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [IFL_ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWr(a, d, r);
    chkResp(r, IFL_RESP_OKAY);
  endtask

  task automatic rdChk(input logic [IFL_ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(a, d, r);
    chk(d, exp);
    chkResp(r, IFL_RESP_OKAY);
  endtask

  task automatic chkIrq(input logic exp);
    @(negedge mclk);
    chk({31'h0, busIrq}, {31'h0, exp});
    @(posedge mclk);
  endtask

  // One byte on the bus, then time for the synchroniser and status update
  task automatic xfer(input logic [7:0] b, input logic expAck);
    logic ack;
    mst_u.sendByte(b, ack);
    chk({31'h0, ack}, {31'h0, expAck});
    repeat (10) @(posedge mclk);
  endtask

  task automatic pulseArb();
    arbLostEvt <= 1'b1;
    @(posedge mclk);
    arbLostEvt <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic w;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 5; i++) rdChk(IFL_ADDR_W'(i * 4), 32'h0);
    axiRd(5'h14, d, r);
    chkResp(r, IFL_RESP_SLVERR);
    axiWr(5'h14, 32'hFFFFFFFF, r);
    chkResp(r, IFL_RESP_SLVERR);
    // Own 7-bit address, mask off: flag set but no request
    wr(IFL_OFS_OWN, 32'h2A);
    mst_u.startCond();
    xfer(8'h54, 1'b1);
    rdChk(IFL_OFS_STAT, 32'h7);
    chkIrq(1'b0);
    xfer(8'hA5, 1'b1);
    rdChk(IFL_OFS_DATA, 32'hA5);
    wr(IFL_OFS_MASK, 32'h1);
    chkIrq(1'b1);
    wr(IFL_OFS_STAT, 32'h0);
    rdChk(IFL_OFS_STAT, 32'h7);
    wr(IFL_OFS_STAT, 32'h1);
    rdChk(IFL_OFS_STAT, 32'h6);
    chkIrq(1'b0);
    wr(IFL_OFS_STAT, 32'h6);
    mst_u.stopCond();
    // Foreign address and disabled general call are ignored
    mst_u.startCond();
    xfer(8'h60, 1'b0);
    mst_u.stopCond();
    mst_u.startCond();
    xfer(8'h00, 1'b0);
    mst_u.stopCond();
    rdChk(IFL_OFS_STAT, 32'h0);
    wr(IFL_OFS_CTRL, 32'h1);
    mst_u.startCond();
    xfer(8'h00, 1'b1);
    rdChk(IFL_OFS_STAT, 32'h7);
    rdChk(IFL_OFS_DATA, 32'h0);
    mst_u.stopCond();
    wr(IFL_OFS_STAT, 32'h7);
    // Arbitration loss, then a new loss landing on the clearing write
    pulseArb();
    rdChk(IFL_OFS_STAT, 32'h9);
    chkIrq(1'b1);
    fork
      axiWr(IFL_OFS_STAT, 32'h9, r);
      begin
        do begin
          @(negedge mclk);
          w = s_axi_wready;
          @(posedge mclk);
        end while (!w);
        pulseArb();
      end
    join
    rdChk(IFL_OFS_STAT, 32'h9);
    wr(IFL_OFS_STAT, 32'h9);
    rdChk(IFL_OFS_STAT, 32'h0);
    chkIrq(1'b0);
    // Ten-bit address: first byte alone interrupts, software skips the data
    wr(IFL_OFS_CTRL, 32'h2);
    wr(IFL_OFS_OWN, 32'h2C5);
    mst_u.startCond();
    xfer(8'hF4, 1'b1);
    rdChk(IFL_OFS_STAT, 32'h3);
    chkIrq(1'b1);
    wr(IFL_OFS_STAT, 32'h3);
    xfer(8'hC5, 1'b1);
    axiRd(IFL_OFS_STAT, d, r);
    chk({31'h0, d[2]}, 32'h1);
    wr(IFL_OFS_STAT, 32'h7);
    // Repeated start with read: the remembered header lets us answer until stop
    mst_u.startCond();
    xfer(8'hF5, 1'b1);
    rdChk(IFL_OFS_STAT, 32'h7);
    wr(IFL_OFS_STAT, 32'h7);
    mst_u.stopCond();
    mst_u.startCond();
    xfer(8'hF5, 1'b0);
    mst_u.stopCond();
    rdChk(IFL_OFS_STAT, 32'h0);
    summarize();
  end
endmodule
